// file: src/tsp_pkg.sv
// constants for the time-slot serial port
package tsp_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SLOTS_PER_FRAME = 16;
  localparam int BITS_PER_FRAME = 256;
  localparam logic [7:0] BCLK_DIV_HALF = 8'h04;
  localparam logic [3:0] CTRL_SLOT_A = 4'h0;
  localparam logic [3:0] CTRL_SLOT_B = 4'h1;
  localparam logic [15:0] TX_IDLE_WORD = 16'h0000;
  localparam logic [7:0] FS_DIV_BITS = 8'hff;
endpackage

// file: src/word_fifo.sv
// parameterised valid/ready word fifo
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] wr_ptr_nxt;
  logic [AW:0] rd_ptr_nxt;
  logic wr_ready_r;
  logic do_wr;
  logic do_rd;
  // registered ready keeps the write side free of a combinational path
  assign wr_ready_out = wr_ready_r;
  assign wr_ptr_nxt = wr_ptr_r + (AW+1)'(do_wr);
  assign rd_ptr_nxt = rd_ptr_r + (AW+1)'(do_rd);
  assign rd_valid_out = wr_ptr_r != rd_ptr_r;
  assign rd_data_out = mem[rd_ptr_r[AW-1:0]];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      wr_ready_r <= 1'b1;
    end else begin
      wr_ready_r <= (wr_ptr_nxt - rd_ptr_nxt) != (AW+1)'(DEPTH);
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// file: src/tsp_port.sv
// time-slot serial port of a dual-channel voice codec
//
// Functional notes
// - master drives bit clock at 256x frame rate
// - sample input on bit clock fall, own slots
// - channel 1 first slot, channel 2 second
// - launch output on bit clock rise
// - output released outside own slots
// - channel 1 sends first slot, channel 2 second
// - frame sync high starts frame, slot 0
// - frame sync sampled on bit clock rise
// - only master drives frame sync
// - two address pins pick slot pair, msb first
// - control select low: slots 0,1 carry control, except at address 0 where they carry channels 1 and 2
// - control select high: slots 0,1 ignored, except at address 0 where they carry channels 1 and 2
// - all timing from the master clock
`timescale 1ns/1ps
module tsp_port (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic MASTER_MODE_IN,
  input wire logic CTRL_SEL_IN,
  input wire logic SLOT_ADDR_MSB_IN,
  input wire logic SLOT_ADDR_LSB_IN,
  input wire logic BCLK_IN,
  output logic BCLK_OUT,
  output logic BCLK_OE_OUT,
  input wire logic FRAME_SYNC_IN,
  output logic FRAME_SYNC_OUT,
  output logic FRAME_SYNC_OE_OUT,
  input wire logic DIN_IN,
  output logic DOUT_OUT,
  output logic DOUT_OE_OUT,
  input wire logic [15:0] TX1_DATA_IN,
  input wire logic TX1_VALID_IN,
  output logic TX1_READY_OUT,
  input wire logic [15:0] TX2_DATA_IN,
  input wire logic TX2_VALID_IN,
  output logic TX2_READY_OUT,
  output logic [15:0] RX1_DATA_OUT,
  output logic RX1_VALID_OUT,
  output logic [15:0] RX2_DATA_OUT,
  output logic RX2_VALID_OUT,
  input wire logic RX_READY_IN,
  output logic [15:0] CTRL_DATA_OUT,
  output logic CTRL_VALID_OUT,
  output logic RX_OVERRUN_OUT
);
  localparam int W = tsp_pkg::WORD_W;

  function automatic logic [3:0] pair_slot(input logic [1:0] addr,
                                           input logic second);
    pair_slot = {1'b0, addr, second};
  endfunction

  // input synchronisers
  logic [1:0] bclk_s_r, fs_s_r, din_s_r, ms_s_r, cs_s_r, a1_s_r, a0_s_r;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bclk_s_r <= '0;
      fs_s_r <= '0;
      din_s_r <= '0;
      ms_s_r <= '0;
      cs_s_r <= '0;
      a1_s_r <= '0;
      a0_s_r <= '0;
    end else begin
      bclk_s_r <= {bclk_s_r[0], BCLK_IN};
      fs_s_r <= {fs_s_r[0], FRAME_SYNC_IN};
      din_s_r <= {din_s_r[0], DIN_IN};
      ms_s_r <= {ms_s_r[0], MASTER_MODE_IN};
      cs_s_r <= {cs_s_r[0], CTRL_SEL_IN};
      a1_s_r <= {a1_s_r[0], SLOT_ADDR_MSB_IN};
      a0_s_r <= {a0_s_r[0], SLOT_ADDR_LSB_IN};
    end
  end
  logic master;
  assign master = ms_s_r[1];

  // master bit clock and frame sync generator
  logic [7:0] div_r;
  logic gen_bclk_r;
  logic [7:0] gen_bit_r;
  logic gen_fs_r;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      div_r <= '0;
      gen_bclk_r <= 1'b0;
      gen_bit_r <= '0;
      gen_fs_r <= 1'b0;
    end else if (!master) begin
      div_r <= '0;
      gen_bclk_r <= 1'b0;
      gen_bit_r <= '0;
      gen_fs_r <= 1'b0;
    end else if (div_r == tsp_pkg::BCLK_DIV_HALF - 8'h0_001) begin
      div_r <= '0;
      gen_bclk_r <= !gen_bclk_r;
      if (!gen_bclk_r) begin
        // change fs on falling edge so rising edge sees it stable
      end else begin
        gen_bit_r <= gen_bit_r + 8'h0_001;
        gen_fs_r <= (gen_bit_r == tsp_pkg::FS_DIV_BITS);
      end
    end else begin
      div_r <= div_r + 8'h0_001;
    end
  end

  // pin drivers: master drives both clocks, slave releases
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BCLK_OUT <= 1'b0;
      BCLK_OE_OUT <= 1'b0;
      FRAME_SYNC_OUT <= 1'b0;
      FRAME_SYNC_OE_OUT <= 1'b0;
    end else begin
      BCLK_OUT <= gen_bclk_r;
      BCLK_OE_OUT <= master;
      FRAME_SYNC_OUT <= gen_fs_r;
      FRAME_SYNC_OE_OUT <= master;
    end
  end

  // edge detection on the bit clock seen at the pin
  logic bclk_d_r;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bclk_d_r <= 1'b0;
    end else begin
      bclk_d_r <= bclk_s_r[1];
    end
  end
  logic rise, fall;
  assign rise = bclk_s_r[1] && !bclk_d_r;
  assign fall = !bclk_s_r[1] && bclk_d_r;

  // frame position
  logic [7:0] bit_cnt_r;
  logic in_frame_r;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bit_cnt_r <= '0;
      in_frame_r <= 1'b0;
    end else if (rise) begin
      if (fs_s_r[1]) begin
        bit_cnt_r <= '0;
        in_frame_r <= 1'b1;
      end else if (in_frame_r) begin
        bit_cnt_r <= bit_cnt_r + 8'h0_001;
        if (bit_cnt_r == tsp_pkg::FS_DIV_BITS) begin
          in_frame_r <= 1'b0;
        end
      end
    end
  end
  logic [3:0] slot;
  logic [3:0] bit_idx;
  assign slot = bit_cnt_r[7:4];
  assign bit_idx = bit_cnt_r[3:0];

  logic [1:0] addr;
  assign addr = {a1_s_r[1], a0_s_r[1]};
  logic own1, own2, ctrl_slot;
  assign own1 = in_frame_r && slot == pair_slot(addr, 1'b0);
  assign own2 = in_frame_r && slot == pair_slot(addr, 1'b1);
  assign ctrl_slot = in_frame_r && !cs_s_r[1] &&
    (slot == tsp_pkg::CTRL_SLOT_A || slot == tsp_pkg::CTRL_SLOT_B);

  // transmit fifos
  logic [W-1:0] t1_data, t2_data;
  logic t1_valid, t2_valid, t1_pop, t2_pop;
  word_fifo #(.WIDTH(W), .DEPTH(tsp_pkg::FIFO_DEPTH)) u_tx1 (
    .clk_in(CLK_IN), .rst_in(RST_IN),
    .wr_data_in(TX1_DATA_IN), .wr_valid_in(TX1_VALID_IN),
    .wr_ready_out(TX1_READY_OUT),
    .rd_data_out(t1_data), .rd_valid_out(t1_valid), .rd_ready_in(t1_pop)
  );
  word_fifo #(.WIDTH(W), .DEPTH(tsp_pkg::FIFO_DEPTH)) u_tx2 (
    .clk_in(CLK_IN), .rst_in(RST_IN),
    .wr_data_in(TX2_DATA_IN), .wr_valid_in(TX2_VALID_IN),
    .wr_ready_out(TX2_READY_OUT),
    .rd_data_out(t2_data), .rd_valid_out(t2_valid), .rd_ready_in(t2_pop)
  );

  // shifter loads at slot start on rising edge, msb first
  logic [W-1:0] tx_sh_r;
  logic [7:0] nb;
  assign nb = fs_s_r[1] ? 8'h0_000 : bit_cnt_r + 8'h0_001;
  logic nown1, nown2, nvalid;
  assign nvalid = fs_s_r[1] ||
    (in_frame_r && bit_cnt_r != tsp_pkg::FS_DIV_BITS);
  assign nown1 = nvalid && nb[7:4] == pair_slot(addr, 1'b0);
  assign nown2 = nvalid && nb[7:4] == pair_slot(addr, 1'b1);
  assign t1_pop = rise && nown1 && nb[3:0] == 4'h0 && t1_valid;
  assign t2_pop = rise && nown2 && nb[3:0] == 4'h0 && t2_valid;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_sh_r <= '0;
      DOUT_OUT <= 1'b0;
      DOUT_OE_OUT <= 1'b0;
    end else if (rise) begin
      DOUT_OE_OUT <= nown1 || nown2;
      if ((nown1 || nown2) && nb[3:0] == 4'h0) begin
        if (nown1) begin
          DOUT_OUT <= t1_valid ? t1_data[W-1] : 1'b0;
          tx_sh_r <= {t1_valid ? t1_data[W-2:0] : 15'h0_000, 1'b0};
        end else begin
          DOUT_OUT <= t2_valid ? t2_data[W-1] : 1'b0;
          tx_sh_r <= {t2_valid ? t2_data[W-2:0] : 15'h0_000, 1'b0};
        end
      end else if (nown1 || nown2) begin
        DOUT_OUT <= tx_sh_r[W-1];
        tx_sh_r <= {tx_sh_r[W-2:0], 1'b0};
      end else begin
        DOUT_OUT <= 1'b0;
      end
    end
  end

  // receive on falling edge
  logic [W-1:0] rx_sh_r;
  logic [W-1:0] rx_word;
  assign rx_word = {rx_sh_r[W-2:0], din_s_r[1]};
  logic word_end;
  assign word_end = fall && bit_idx == 4'hf;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_sh_r <= '0;
    end else if (fall && (own1 || own2 || ctrl_slot)) begin
      rx_sh_r <= rx_word;
    end
  end

  // delivered words hold until taken or until the next word for the same output replaces them
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RX1_DATA_OUT <= '0;
      RX1_VALID_OUT <= 1'b0;
      RX2_DATA_OUT <= '0;
      RX2_VALID_OUT <= 1'b0;
      CTRL_DATA_OUT <= '0;
      CTRL_VALID_OUT <= 1'b0;
      RX_OVERRUN_OUT <= 1'b0;
    end else begin
      if (RX_READY_IN) begin
        RX1_VALID_OUT <= 1'b0;
        RX2_VALID_OUT <= 1'b0;
        CTRL_VALID_OUT <= 1'b0;
      end
      if (word_end && own1) begin
        RX1_DATA_OUT <= rx_word;
        RX1_VALID_OUT <= 1'b1;
        RX_OVERRUN_OUT <= RX1_VALID_OUT && !RX_READY_IN;
      end
      if (word_end && own2) begin
        RX2_DATA_OUT <= rx_word;
        RX2_VALID_OUT <= 1'b1;
        RX_OVERRUN_OUT <= RX2_VALID_OUT && !RX_READY_IN;
      end
      if (word_end && ctrl_slot && !own1 && !own2) begin
        CTRL_DATA_OUT <= rx_word;
        CTRL_VALID_OUT <= 1'b1;
      end
    end
  end
endmodule

// file: dv/tsp_port_asserts.sv
// pin-level assertions for the time-slot serial port
`timescale 1ns/1ps
module tsp_port_asserts (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic MASTER_MODE_IN,
  input wire logic CTRL_SEL_IN,
  input wire logic BCLK_IN,
  input wire logic BCLK_OUT,
  input wire logic BCLK_OE_OUT,
  input wire logic FRAME_SYNC_OUT,
  input wire logic FRAME_SYNC_OE_OUT,
  input wire logic DOUT_OUT,
  input wire logic DOUT_OE_OUT,
  input wire logic [15:0] RX1_DATA_OUT,
  input wire logic RX1_VALID_OUT,
  input wire logic [15:0] RX2_DATA_OUT,
  input wire logic RX2_VALID_OUT,
  input wire logic RX_READY_IN,
  input wire logic CTRL_VALID_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence bclk_high;
    BCLK_OUT [*4] ##1 !BCLK_OUT;
  endsequence
  sequence fs_pulse;
    FRAME_SYNC_OUT [*8] ##1 !FRAME_SYNC_OUT;
  endsequence
  a_master_pins_on: assert property (
    MASTER_MODE_IN [*8] |-> BCLK_OE_OUT && FRAME_SYNC_OE_OUT)
    else $error("master pins not driven");
  a_bclk_half_period: assert property (
    disable iff (RST_IN || !MASTER_MODE_IN)
    $rose(BCLK_OUT) && BCLK_OE_OUT |-> bclk_high)
    else $error("bit clock half period wrong");
  a_fs_one_bit: assert property (
    disable iff (RST_IN || !MASTER_MODE_IN)
    $rose(FRAME_SYNC_OUT) |-> fs_pulse)
    else $error("frame sync width wrong");
  a_slave_pins_off: assert property (
    !MASTER_MODE_IN [*6] |-> !BCLK_OE_OUT && !FRAME_SYNC_OE_OUT)
    else $error("slave drives clock pins");
  a_dout_rise_launch: assert property (
    $fell(BCLK_IN) && DOUT_OE_OUT |-> $stable(DOUT_OUT) [*8])
    else $error("data out moved after falling edge");
  a_oe_after_rise: assert property (
    $rose(DOUT_OE_OUT) && !MASTER_MODE_IN |-> BCLK_IN && $past(BCLK_IN, 2))
    else $error("output enable not on rising edge");
  a_rx1_word_held: assert property (
    RX1_VALID_OUT && !RX_READY_IN |=> RX1_VALID_OUT && $stable(RX1_DATA_OUT))
    else $error("channel 1 word dropped");
  a_rx2_word_held: assert property (
    RX2_VALID_OUT && !RX_READY_IN |=> RX2_VALID_OUT && $stable(RX2_DATA_OUT))
    else $error("channel 2 word dropped");
  a_ctrl_ignored: assert property (
    CTRL_SEL_IN [*4] |-> !$rose(CTRL_VALID_OUT))
    else $error("control word while ignored");
endmodule
bind tsp_port tsp_port_asserts chk (.CLK_IN, .RST_IN, .MASTER_MODE_IN,
  .CTRL_SEL_IN, .BCLK_IN, .BCLK_OUT, .BCLK_OE_OUT, .FRAME_SYNC_OUT,
  .FRAME_SYNC_OE_OUT, .DOUT_OUT, .DOUT_OE_OUT, .RX1_DATA_OUT,
  .RX1_VALID_OUT, .RX2_DATA_OUT, .RX2_VALID_OUT, .RX_READY_IN,
  .CTRL_VALID_OUT);

// file: dv/tsp_host_model.sv
// behavioural host driving bit clock, frame sync and data in
`timescale 1ns/1ps
module tsp_host_model (
  output logic bclk_out,
  output logic fs_out,
  output logic din_out,
  input wire logic dout_in,
  input wire logic dout_oe_in
);
  logic [15:0] tx_w [16];
  logic [15:0] rx_w [16];
  logic [15:0] rx_oe;
  initial begin
    bclk_out = 1'b0;
    fs_out = 1'b0;
    din_out = 1'b0;
  end
  // clock only within frames, 125 ns period
  task automatic frame();
    for (int s = 0; s < 16; s++) begin
      for (int b = 15; b >= 0; b--) begin
        fs_out = (s == 0 && b == 15);
        #62.5 bclk_out = 1;
        din_out = tx_w[s][b];
        #62.5 bclk_out = 0;
        rx_w[s][b] = dout_oe_in ? dout_in : ~dout_in; // released line
        rx_oe[s] = dout_oe_in;
      end
    end
    din_out = ~din_out;
  endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the time-slot serial port
`timescale 1ns/1ps
module tb;
  logic CLK_IN, RST_IN, MASTER_MODE_IN, CTRL_SEL_IN, SLOT_ADDR_MSB_IN;
  logic SLOT_ADDR_LSB_IN, BCLK_IN, BCLK_OUT, BCLK_OE_OUT, FRAME_SYNC_IN;
  logic FRAME_SYNC_OUT, FRAME_SYNC_OE_OUT, DIN_IN, DOUT_OUT, DOUT_OE_OUT;
  logic [15:0] TX1_DATA_IN, TX2_DATA_IN, RX1_DATA_OUT, RX2_DATA_OUT;
  logic [15:0] CTRL_DATA_OUT;
  logic TX1_VALID_IN, TX1_READY_OUT, TX2_VALID_IN, TX2_READY_OUT;
  logic RX1_VALID_OUT, RX2_VALID_OUT, RX_READY_IN, CTRL_VALID_OUT;
  logic RX_OVERRUN_OUT;
  logic [15:0] ctrl_q [$];
  int fail_count = 0;
  int check_count = 0;
  tsp_port uut (.CLK_IN, .RST_IN, .MASTER_MODE_IN, .CTRL_SEL_IN,
    .SLOT_ADDR_MSB_IN, .SLOT_ADDR_LSB_IN, .BCLK_IN, .BCLK_OUT, .BCLK_OE_OUT,
    .FRAME_SYNC_IN, .FRAME_SYNC_OUT, .FRAME_SYNC_OE_OUT, .DIN_IN, .DOUT_OUT,
    .DOUT_OE_OUT, .TX1_DATA_IN, .TX1_VALID_IN, .TX1_READY_OUT, .TX2_DATA_IN,
    .TX2_VALID_IN, .TX2_READY_OUT, .RX1_DATA_OUT, .RX1_VALID_OUT,
    .RX2_DATA_OUT, .RX2_VALID_OUT, .RX_READY_IN, .CTRL_DATA_OUT,
    .CTRL_VALID_OUT, .RX_OVERRUN_OUT);
  tsp_host_model m (.bclk_out(BCLK_IN), .fs_out(FRAME_SYNC_IN),
    .din_out(DIN_IN), .dout_in(DOUT_OUT), .dout_oe_in(DOUT_OE_OUT));
  initial begin
    CLK_IN = 0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end
  always @(posedge CLK_IN) begin
    if (CTRL_VALID_OUT === 1'b1 &&
        (ctrl_q.size() == 0 || ctrl_q[$] !== CTRL_DATA_OUT))
      ctrl_q.push_back(CTRL_DATA_OUT);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic load(input logic [15:0] a, input logic [15:0] b);
    @(posedge CLK_IN) #1;
    TX1_DATA_IN = a;
    TX2_DATA_IN = b;
    TX1_VALID_IN = 1;
    TX2_VALID_IN = 1;
    @(posedge CLK_IN) #1;
    TX1_VALID_IN = 0;
    TX2_VALID_IN = 0;
  endtask
  task automatic run_frame(input logic [1:0] a, input logic sel);
    @(posedge CLK_IN) #1;
    {SLOT_ADDR_MSB_IN, SLOT_ADDR_LSB_IN} = a;
    CTRL_SEL_IN = sel;
    for (int s = 0; s < 16; s++) m.tx_w[s] = 16'h5a00 | 16'(s);
    repeat (8) @(posedge CLK_IN);
    m.frame();
    repeat (40) @(posedge CLK_IN);
    #1;
  endtask
  task automatic take(input logic [15:0] a, input logic [15:0] b);
    check(16'(RX1_VALID_OUT & RX2_VALID_OUT), 16'h0001);
    check(RX1_DATA_OUT, a);
    check(RX2_DATA_OUT, b);
    check(16'(RX_OVERRUN_OUT), 16'h0000);
    RX_READY_IN = 1;
    @(posedge CLK_IN) #1;
    RX_READY_IN = 0;
    @(posedge CLK_IN) #1;
    check(16'(RX1_VALID_OUT | RX2_VALID_OUT), 16'h0000);
    check(16'(CTRL_VALID_OUT), 16'h0000);
  endtask
  task automatic test_slots();
    for (int a = 1; a < 4; a++) begin
      load(16'h1100 + 16'(a), 16'h2200 + 16'(a));
      run_frame(2'(a), 1'b1);
      check(m.rx_oe, 16'h0003 << (2 * a));
      check(m.rx_w[2*a], 16'h1100 + 16'(a));
      check(m.rx_w[2*a+1], 16'h2200 + 16'(a));
      take(16'h5a00 | 16'(2 * a), 16'h5a01 | 16'(2 * a));
    end
    check(16'(ctrl_q.size()), 16'h0000);
    $display("test slots done");
  endtask
  task automatic test_ctrl();
    run_frame(2'h2, 1'b0);
    check(16'(ctrl_q.size()), 16'h0002);
    check(ctrl_q[0], 16'h5a00);
    check(ctrl_q[1], 16'h5a01);
    check(m.rx_w[4], tsp_pkg::TX_IDLE_WORD);
    take(16'h5a04, 16'h5a05);
    run_frame(2'h0, 1'b0);
    check(m.rx_oe, 16'h0003);
    check(16'(ctrl_q.size()), 16'h0002);
    check(m.rx_w[1], tsp_pkg::TX_IDLE_WORD);
    take(16'h5a00, 16'h5a01);
    $display("test ctrl done");
  endtask
  task automatic test_full();
    int n;
    n = 0;
    @(posedge CLK_IN) #1;
    TX1_VALID_IN = 1;
    repeat (20) begin
      TX1_DATA_IN = 16'h3000 + 16'(n);
      if (TX1_READY_OUT === 1'b1) n++;
      @(posedge CLK_IN) #1;
    end
    TX1_VALID_IN = 0;
    check(16'(n), 16'(tsp_pkg::FIFO_DEPTH));
    check(16'(TX1_READY_OUT), 16'h0000);
    run_frame(2'h1, 1'b1);
    check(m.rx_w[2], 16'h3000);
    check(16'(TX1_READY_OUT), 16'h0001);
    take(16'h5a02, 16'h5a03);
    $display("test full done");
  endtask
  task automatic test_master();
    int r, k;
    logic pb, pf;
    r = 0;
    k = 0;
    pb = 0;
    pf = 0;
    MASTER_MODE_IN = 1;
    repeat (4500) begin
      @(posedge CLK_IN) #1;
      if (FRAME_SYNC_OUT === 1'b1 && !pf) k++;
      if (BCLK_OUT === 1'b1 && !pb && k == 1) r++;
      pb = BCLK_OUT;
      pf = FRAME_SYNC_OUT;
    end
    check(16'(r), 16'(tsp_pkg::BITS_PER_FRAME));
    check(16'(BCLK_OE_OUT & FRAME_SYNC_OE_OUT), 16'h0001);
    MASTER_MODE_IN = 0;
    repeat (10) @(posedge CLK_IN);
    #1 check(16'(BCLK_OE_OUT | FRAME_SYNC_OE_OUT), 16'h0000);
    $display("test master done");
  endtask
  initial begin
    {RST_IN, MASTER_MODE_IN, CTRL_SEL_IN, RX_READY_IN} = 4'h8;
    {SLOT_ADDR_MSB_IN, SLOT_ADDR_LSB_IN, TX1_VALID_IN, TX2_VALID_IN} = 4'h0;
    TX1_DATA_IN = 16'h0000;
    TX2_DATA_IN = 16'h0000;
    repeat (5) @(posedge CLK_IN);
    #1 RST_IN = 0;
    test_slots();
    test_ctrl();
    test_full();
    test_master();
    stop_test();
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule
